// ---- core/htf_touch_framer.sv ----
// Purpose: builds digitizer touch and stylus report payloads
// Assumes: touch table from acquisition, byte stream to USB engine
// Notes:   byte stream uses valid/ready, last marks end of packet
//
// Summary of operation
// - composite full-speed device at 12 Mbps, two interfaces
// - endpoint zero is the only bidirectional endpoint
// - command interface uses endpoints 0x81 in and 0x02 out
// - all touch reports go out on endpoint 0x83
// - version: major/minor nibbles in high byte, BCD build low
// - report id 0x01, five 11-byte records, scan time, count
// - bytes of unused touch records are zero
// - more than five touches spill into further packets
// - record byte 0: detect in bit 0, touch id above
// - touch identifiers start at 1
// - 12-bit position, low byte first, high nibble zero
// - geometry bytes reserved zero unless geometry enabled
// - contact count nonzero only in first packet of frame
// - scan time at 10 kHz, same in all packets of frame
// - stylus report id 0x03, bytes 0 to 10
// - button byte: tip bit 0, barrel and eraser flags
// - in-range flag set while stylus is detected nearby
// - last stylus byte carries tip pressure
// - any contact status change sends a touch update
// - idle delay set by host, defaults to 2 (8 ms)
module htf_touch_framer
  import htf_pkg::*;
#(
  parameter int MAX_TOUCH = 10
)
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // touch table, one slot per possible contact
  input  wire logic [MAX_TOUCH-1:0]   touch_active,
  input  wire logic [MAX_TOUCH*12-1:0] touch_x,
  input  wire logic [MAX_TOUCH*12-1:0] touch_x2,
  input  wire logic [MAX_TOUCH*12-1:0] touch_y,
  input  wire logic [MAX_TOUCH*12-1:0] touch_y2,
  input  wire logic [MAX_TOUCH*8-1:0] touch_w,
  input  wire logic [MAX_TOUCH*8-1:0] touch_h,
  // host class request
  input  wire logic                   set_idle_valid,
  input  wire logic [7:0]             set_idle_value,
  // payload stream towards the usb engine
  output logic      [7:0]             pkt_data,
  output logic      [7:0]             pkt_endpoint,
  output logic                        pkt_valid,
  output logic                        pkt_last,
  input  wire logic                   pkt_ready
);
  localparam int NPKT = (MAX_TOUCH + HTF_RECS_PER_PKT - 1) /
                        HTF_RECS_PER_PKT;
  localparam logic [5:0] MT6 = 6'(MAX_TOUCH);

  // six-bit ids and the four-bit packet index bound the table size
  if (MAX_TOUCH < 1 || MAX_TOUCH > 63 || NPKT > 16) begin : g_bad_cfg
    $error("MAX_TOUCH must be 1 to 63");
  end

  // registers
  logic [31:0] ctrl_reg;
  logic [15:0] version_reg;
  logic [7:0]  idle_reg;
  logic [31:0] stylus_reg;
  logic [31:0] stypos_reg;
  logic [31:0] stycen_reg;
  logic [15:0] scan_reg;
  logic [15:0] frame_scan_reg;
  logic [15:0] scan_div_reg;
  logic [MAX_TOUCH-1:0] prev_active_reg;
  logic [5:0]  count_reg;
  logic [3:0]  pkt_idx_reg;
  logic [5:0]  byte_idx_reg;
  logic [7:0]  frames_reg;
  htf_state_t  state_reg;
  logic        sty_pend_reg;
  logic [31:0] idle_cnt_reg;
  logic        idle_due_reg;

  logic        wr_en;
  logic        frame_start;
  logic        sty_start;
  logic        byte_take;
  logic        pkt_end;
  logic [5:0]  touch_cnt;
  logic [7:0]  data_next;
  logic [31:0] idle_limit;
  logic [5:0]  slot;
  logic [7:0]  rec_byte [HTF_RECS_PER_PKT];

  assign wr_en     = psel & penable & pwrite;
  assign byte_take = pkt_valid & pkt_ready;

  // zero-wait apb: answer in the access phase
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // control and stylus registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= HTF_CTRL_RST;
      version_reg <= HTF_VERSION_RST;
      stylus_reg  <= 32'h0000_0000;
      stypos_reg  <= 32'h0000_0000;
      stycen_reg  <= 32'h0000_0000;
    end else begin
      if (wr_en && paddr == HTF_OFF_CTRL)
        ctrl_reg <= pwdata;
      if (wr_en && paddr == HTF_OFF_VERSION)
        version_reg <= pwdata[15:0];
      if (wr_en && paddr == HTF_OFF_STYLUS)
        stylus_reg <= pwdata;
      if (wr_en && paddr == HTF_OFF_STYPOS)
        stypos_reg <= pwdata;
      if (wr_en && paddr == HTF_OFF_STYCEN)
        stycen_reg <= pwdata;
      // request bit self-clears once the stylus report starts
      if (sty_start)
        ctrl_reg[HTF_CTRL_STYREQ_BIT] <= 1'b0;
    end
  end

  // idle delay, host request wins over software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      idle_reg <= HTF_IDLE_RST;
    else if (set_idle_valid)
      idle_reg <= set_idle_value;
    else if (wr_en && paddr == HTF_OFF_IDLE)
      idle_reg <= pwdata[7:0];
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      HTF_OFF_CTRL:    prdata = ctrl_reg;
      HTF_OFF_VERSION: prdata = {16'h0000, version_reg};
      HTF_OFF_IDLE:    prdata = {24'h000000, idle_reg};
      HTF_OFF_STATUS:
        prdata = {8'h00, frames_reg, 6'h00, state_reg, 2'h0, count_reg};
      HTF_OFF_STYLUS:  prdata = stylus_reg;
      HTF_OFF_STYPOS:  prdata = stypos_reg;
      HTF_OFF_STYCEN:  prdata = stycen_reg;
      HTF_OFF_ENDPT:
        prdata = {HTF_EP_DIG_IN, HTF_EP_CMD_OUT, HTF_EP_CMD_IN, HTF_EP_CTRL};
      default:         prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_div_reg <= 16'h0000;
      scan_reg     <= 16'h0000;
    end else if (scan_div_reg == 16'(HTF_SCAN_CYCLES - 1)) begin
      scan_div_reg <= 16'h0000;
      scan_reg     <= scan_reg + 16'h0001;
    end else begin
      scan_div_reg <= scan_div_reg + 16'h0001;
    end
  end

  // count of active contacts
  always_comb begin
    touch_cnt = 6'h00;
    for (int i = 0; i < MAX_TOUCH; i++)
      touch_cnt = touch_cnt + {5'h00, touch_active[i]};
  end

  // idle period in clocks; zero disables idle reports
  assign idle_limit = 32'(idle_reg) * 32'(HTF_IDLE_UNIT_MS * HTF_MS_CYCLES);

  // idle timer restarts at each touch frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_reg <= 32'h0000_0000;
      idle_due_reg <= 1'b0;
    end else if (frame_start || idle_reg == 8'h00) begin
      idle_cnt_reg <= 32'h0000_0000;
      idle_due_reg <= 1'b0;
    end else if (idle_cnt_reg >= idle_limit - 32'h1) begin
      idle_due_reg <= 1'b1;
    end else begin
      idle_cnt_reg <= idle_cnt_reg + 32'h1;
    end
  end

  // status change or idle expiry starts a frame
  assign frame_start = (state_reg == HTF_ST_IDLE) &&
                       ((touch_active != prev_active_reg) || idle_due_reg);
  assign sty_start   = (state_reg == HTF_ST_IDLE) && !frame_start &&
                       (sty_pend_reg || ctrl_reg[HTF_CTRL_STYREQ_BIT]);

  assign pkt_end = byte_take && pkt_last;

  // stylus request pending while a touch frame runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sty_pend_reg <= 1'b0;
    else if (sty_start)
      sty_pend_reg <= 1'b0;
    else if (ctrl_reg[HTF_CTRL_STYREQ_BIT])
      sty_pend_reg <= 1'b1;
  end

  // packet sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg       <= HTF_ST_IDLE;
      prev_active_reg <= '0;
      count_reg       <= 6'h00;
      frame_scan_reg  <= 16'h0000;
      pkt_idx_reg     <= 4'h0;
      byte_idx_reg    <= 6'h00;
      frames_reg      <= 8'h00;
    end else begin
      case (state_reg)
        HTF_ST_IDLE: begin
          byte_idx_reg <= 6'h00;
          pkt_idx_reg  <= 4'h0;
          if (frame_start) begin
            // freeze scan time for the whole frame
            frame_scan_reg  <= scan_reg;
            count_reg       <= touch_cnt;
            prev_active_reg <= touch_active;
            frames_reg      <= frames_reg + 8'h01;
            state_reg       <= HTF_ST_TOUCH;
          end else if (sty_start) begin
            state_reg <= HTF_ST_STYL;
          end
        end
        HTF_ST_TOUCH: begin
          if (pkt_end) begin
            byte_idx_reg <= 6'h00;
            // further packets while touches remain
            // seven bits so the product cannot wrap for large tables
            if (({3'b000, pkt_idx_reg} + 7'h01) *
                7'(HTF_RECS_PER_PKT) < {1'b0, count_reg})
              pkt_idx_reg <= pkt_idx_reg + 4'h1;
            else
              state_reg <= HTF_ST_IDLE;
          end else if (byte_take) begin
            byte_idx_reg <= byte_idx_reg + 6'h01;
          end
        end
        HTF_ST_STYL: begin
          if (pkt_end)
            state_reg <= HTF_ST_IDLE;
          else if (byte_take)
            byte_idx_reg <= byte_idx_reg + 6'h01;
        end
        default: state_reg <= HTF_ST_IDLE;
      endcase
    end
  end

  // record slot builders, one per record of a packet
  for (genvar r = 0; r < HTF_RECS_PER_PKT; r++) begin : g_rec
    logic [5:0] s;
    logic [3:0] bidx;
    logic       act;
    assign s    = 6'(pkt_idx_reg * HTF_RECS_PER_PKT + r);
    assign bidx = 4'((byte_idx_reg - 6'h01) % 6'd11);
    // slots past the contact count stay zero
    assign act  = (s < count_reg) && (s < MT6);
    htf_record_byte u_rec (
      .idx     (bidx),
      .active  (act),
      .geom_en (ctrl_reg[HTF_CTRL_GEOM_BIT]),
      .tid     (s + 6'h01),
      .x       (touch_x [(s % MT6)*12 +: 12]),
      .x2      (touch_x2[(s % MT6)*12 +: 12]),
      .y       (touch_y [(s % MT6)*12 +: 12]),
      .y2      (touch_y2[(s % MT6)*12 +: 12]),
      .width   (touch_w [(s % MT6)*8 +: 8]),
      .height  (touch_h [(s % MT6)*8 +: 8]),
      .data    (rec_byte[r])
    );
  end

  assign slot = (byte_idx_reg - 6'h01) / 6'd11;

  // byte selection; records carry table slots 0 onward in order, one per contact counted
  always_comb begin
    data_next = 8'h00;
    if (state_reg == HTF_ST_TOUCH) begin
      if (byte_idx_reg == 6'h00)
        data_next = HTF_RID_TOUCH;
      else if (byte_idx_reg < 6'(HTF_SCAN_BYTE))
        data_next = rec_byte[slot[2:0]];
      else if (byte_idx_reg == 6'(HTF_SCAN_BYTE))
        data_next = frame_scan_reg[7:0];
      else if (byte_idx_reg == 6'(HTF_SCAN_BYTE + 1))
        data_next = frame_scan_reg[15:8];
      else if (pkt_idx_reg == 4'h0)
        data_next = {2'b00, count_reg};
    end else if (state_reg == HTF_ST_STYL) begin
      case (byte_idx_reg)
        6'd0: data_next = HTF_RID_STYLUS;
        6'd1: data_next = {3'b000, stylus_reg[4], 1'b0, stylus_reg[2:0]};
        6'd2: data_next = stypos_reg[7:0];
        6'd3: data_next = stypos_reg[15:8];
        6'd4: data_next = stycen_reg[7:0];
        6'd5: data_next = stycen_reg[15:8];
        6'd6: data_next = stypos_reg[23:16];
        6'd7: data_next = stypos_reg[31:24];
        6'd8: data_next = stycen_reg[23:16];
        6'd9: data_next = stycen_reg[31:24];
        6'd10: data_next = stylus_reg[15:8];
        default: data_next = 8'h00;
      endcase
    end
  end

  // bytes handed to the full-speed engine
  assign pkt_data  = data_next;
  assign pkt_valid = (state_reg == HTF_ST_TOUCH) ||
                     (state_reg == HTF_ST_STYL);
  assign pkt_last  = (state_reg == HTF_ST_TOUCH) ?
                     (byte_idx_reg == 6'(HTF_TOUCH_LEN - 1)) :
                     (byte_idx_reg == 6'(HTF_STYLUS_LEN - 1));
  assign pkt_endpoint = HTF_EP_DIG_IN;
endmodule

// ---- include/htf_pkg.sv ----
// Purpose: shared constants for the touch report framer
// Assumes: 200 MHz pclk, APB register access
// Notes:   offsets are byte addresses of 32-bit words
package htf_pkg;
  // register byte offsets
  localparam logic [7:0] HTF_OFF_CTRL    = 8'h00;
  localparam logic [7:0] HTF_OFF_VERSION = 8'h04;
  localparam logic [7:0] HTF_OFF_IDLE    = 8'h08;
  localparam logic [7:0] HTF_OFF_STATUS  = 8'h0C;
  localparam logic [7:0] HTF_OFF_STYLUS  = 8'h10;
  localparam logic [7:0] HTF_OFF_STYPOS  = 8'h14;
  localparam logic [7:0] HTF_OFF_STYCEN  = 8'h18;
  localparam logic [7:0] HTF_OFF_ENDPT   = 8'h1C;
  // control fields
  localparam int HTF_CTRL_GEOM_BIT    = 0;
  localparam int HTF_CTRL_STYREQ_BIT  = 1;
  localparam logic [31:0] HTF_CTRL_RST = 32'h0000_0000;
  // version field reset value, arbitrary
  localparam logic [15:0] HTF_VERSION_RST = 16'h1000;
  // idle delay default, units of 4 ms
  localparam logic [7:0] HTF_IDLE_RST = 8'h02;
  localparam int HTF_IDLE_UNIT_MS = 4;
  // endpoint map
  localparam logic [7:0] HTF_EP_CTRL    = 8'h00;
  localparam logic [7:0] HTF_EP_CMD_IN  = 8'h81;
  localparam logic [7:0] HTF_EP_CMD_OUT = 8'h02;
  localparam logic [7:0] HTF_EP_DIG_IN  = 8'h83;
  // report layout
  localparam logic [7:0] HTF_RID_TOUCH  = 8'h01;
  localparam logic [7:0] HTF_RID_STYLUS = 8'h03;
  localparam int HTF_REC_BYTES    = 11;
  localparam int HTF_RECS_PER_PKT = 5;
  localparam int HTF_TOUCH_LEN    = 59;
  localparam int HTF_STYLUS_LEN   = 11;
  localparam int HTF_SCAN_BYTE    = 56;
  localparam int HTF_COUNT_BYTE   = 58;
  // timing
  localparam int HTF_CLK_HZ      = 200_000_000;
  localparam int HTF_SCAN_HZ     = 10_000;
  localparam int HTF_SCAN_CYCLES = HTF_CLK_HZ / HTF_SCAN_HZ;
  localparam int HTF_MS_CYCLES   = HTF_CLK_HZ / 1000;
  localparam int HTF_USB_BPS     = 12_000_000;
  // packet kinds
  typedef enum logic [1:0] {
    HTF_ST_IDLE  = 2'b00,
    HTF_ST_TOUCH = 2'b01,
    HTF_ST_STYL  = 2'b10
  } htf_state_t;
endpackage

// ---- core/htf_record_byte.sv ----
// Purpose: one byte of an 11-byte touch record
// Assumes: position values are 12 bits wide
// Notes:   purely combinational, one instance per record slot
module htf_record_byte
  import htf_pkg::*;
(
  input  wire logic [3:0]  idx,
  input  wire logic        active,
  input  wire logic        geom_en,
  input  wire logic [5:0]  tid,
  input  wire logic [11:0] x,
  input  wire logic [11:0] x2,
  input  wire logic [11:0] y,
  input  wire logic [11:0] y2,
  input  wire logic [7:0]  width,
  input  wire logic [7:0]  height,
  output logic      [7:0]  data
);
  // byte selection inside a record; inactive slots are zero
  always_comb begin
    data = 8'h00;
    if (active) begin
      case (idx)
        4'h0: data = {tid, 1'b0, 1'b1};
        4'h1: data = x[7:0];
        4'h2: data = {4'h0, x[11:8]};
        4'h3: data = geom_en ? x2[7:0] : 8'h00;
        4'h4: data = geom_en ? {4'h0, x2[11:8]} : 8'h00;
        4'h5: data = y[7:0];
        4'h6: data = {4'h0, y[11:8]};
        4'h7: data = geom_en ? y2[7:0] : 8'h00;
        4'h8: data = geom_en ? {4'h0, y2[11:8]} : 8'h00;
        4'h9: data = geom_en ? width : 8'h00;
        4'hA: data = geom_en ? height : 8'h00;
        default: data = 8'h00;
      endcase
    end
  end
endmodule

// ---- verif/htf_framer_props.sv ----
// Purpose: concurrent checks on the framer's stream and apb ports
// Assumes: single pclk domain, presetn async active low
// Notes:   byte position is rebuilt from the handshake itself
module htf_framer_props
  import htf_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [7:0] pkt_data,
  input wire logic [7:0] pkt_endpoint,
  input wire logic       pkt_valid,
  input wire logic       pkt_last,
  input wire logic       pkt_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] cnt_reg;
  logic       sty_reg;
  logic [6:0] rpos;
  // byte index within the packet, cleared when the last byte moves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cnt_reg <= 7'h00;
    else if (pkt_valid && pkt_ready)
      cnt_reg <= pkt_last ? 7'h00 : cnt_reg + 7'h01;
  end
  // packet kind latched from the report id byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sty_reg <= 1'b0;
    else if (pkt_valid && pkt_ready && cnt_reg == 7'h00)
      sty_reg <= (pkt_data == HTF_RID_STYLUS);
  end
  // offset inside an 11-byte record, only meaningful for bytes 1..55
  assign rpos = (cnt_reg - 7'h01) % 7'd11;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ep_fixed: assert property (
    pkt_valid |-> pkt_endpoint == HTF_EP_DIG_IN)
    else $error("endpoint is not the digitizer endpoint");
  a_valid_hold: assert property (
    pkt_valid && !pkt_ready |=> pkt_valid)
    else $error("valid dropped before the byte was taken");
  a_data_hold: assert property (
    pkt_valid && !pkt_ready |=> $stable(pkt_data) && $stable(pkt_last))
    else $error("stalled byte changed");
  a_report_id: assert property (
    pkt_valid && cnt_reg == 7'h00 |->
      pkt_data == HTF_RID_TOUCH || pkt_data == HTF_RID_STYLUS)
    else $error("packet does not start with a report id");
  a_touch_len: assert property (
    pkt_valid && pkt_last && !sty_reg |-> cnt_reg == 7'd58)
    else $error("touch packet length wrong");
  a_stylus_len: assert property (
    pkt_valid && pkt_last && sty_reg |-> cnt_reg == 7'd10)
    else $error("stylus packet length wrong");
  a_pos_nibble: assert property (
    pkt_valid && !sty_reg && cnt_reg inside {[1:55]} &&
      rpos inside {2, 4, 6, 8} |-> pkt_data[7:4] == 4'h0)
    else $error("position high byte has upper bits set");
  a_apb_answer: assert property (
    psel && penable |-> pready && !pslverr)
    else $error("apb access not answered cleanly");
  c_touch_end: cover property (pkt_valid && pkt_ready && pkt_last && !sty_reg);
  c_stylus_end: cover property (pkt_valid && pkt_ready && pkt_last && sty_reg);
  c_stall: cover property (pkt_valid && !pkt_ready ##1 pkt_valid && pkt_ready);
endmodule

bind htf_touch_framer htf_framer_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .pkt_data(pkt_data),
  .pkt_endpoint(pkt_endpoint), .pkt_valid(pkt_valid),
  .pkt_last(pkt_last), .pkt_ready(pkt_ready)
);

// ---- verif/htf_usb_host.sv ----
// Purpose: behavioural usb host side that drains report packets
// Assumes: one byte per pclk handshake
// Notes:   slow mode takes a byte only one cycle in four
module htf_usb_host (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       slow,
  input  wire logic [7:0] pkt_data,
  input  wire logic       pkt_valid,
  input  wire logic       pkt_last,
  output logic            pkt_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:511];
  int         wp;
  int         npkt;
  int         pend [0:15];
  logic [1:0] ph;
  // full-speed host polling, stalls to mimic slow bus slots
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph        <= 2'b00;
      pkt_ready <= 1'b0;
    end else begin
      ph        <= ph + 2'b01;
      pkt_ready <= slow ? (ph == 2'b00) : 1'b1;
    end
  end
  // capture every byte; packet end offsets kept for the bench
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp   <= 0;
      npkt <= 0;
    end else if (pkt_valid && pkt_ready) begin
      mem[wp] <= pkt_data;
      wp      <= wp + 1;
      if (pkt_last) begin
        pend[npkt] <= wp + 1;
        npkt       <= npkt + 1;
      end
    end
  end
endmodule

// ---- verif/tb.sv ----
// Purpose: directed bench for the touch report framer
// Assumes: apb answers with zero waits, host model drains packets
// Notes:   idle reports are switched off so frames stay change driven
module tb;
  import htf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, slow;
  logic [7:0]  paddr, pkt_data, pkt_endpoint, set_idle_value;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, pkt_valid, pkt_last, pkt_ready;
  logic        set_idle_valid;
  logic [9:0]  touch_active;
  logic [119:0] touch_x, touch_x2, touch_y, touch_y2;
  logic [79:0] touch_w, touch_h;
  int          bad_count, n_tests, b;
  logic [7:0]  sty [0:10] = '{8'h03, 8'h17, 8'h23, 8'h01, 8'hBC, 8'h0A,
                              8'h56, 8'h04, 8'h89, 8'h07, 8'h5A};
  htf_touch_framer #(.MAX_TOUCH(10)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .touch_active(touch_active),
    .touch_x(touch_x), .touch_x2(touch_x2), .touch_y(touch_y),
    .touch_y2(touch_y2), .touch_w(touch_w), .touch_h(touch_h),
    .set_idle_valid(set_idle_valid), .set_idle_value(set_idle_value),
    .pkt_data(pkt_data), .pkt_endpoint(pkt_endpoint),
    .pkt_valid(pkt_valid), .pkt_last(pkt_last), .pkt_ready(pkt_ready));
  htf_usb_host u_host (
    .pclk(pclk), .presetn(presetn), .slow(slow), .pkt_data(pkt_data),
    .pkt_valid(pkt_valid), .pkt_last(pkt_last), .pkt_ready(pkt_ready));
  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // load n contacts in one edge so a single frame results
  task automatic load(input int n);
    @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      touch_x[i*12+:12]  <= 12'hA50 + 12'(i);
      touch_x2[i*12+:12] <= 12'h960 + 12'(i);
      touch_y[i*12+:12]  <= 12'h870 + 12'(i);
      touch_y2[i*12+:12] <= 12'h780 + 12'(i);
      touch_w[i*8+:8]    <= 8'h10 + 8'(i);
      touch_h[i*8+:8]    <= 8'h20 + 8'(i);
      touch_active[i] <= (i < n);
    end
  endtask
  function automatic logic [7:0] rec(input int s, input int k, input logic g);
    logic [11:0] v;
    v = (k < 3) ? 12'hA50 : (k < 5) ? 12'h960 : (k < 7) ? 12'h870 : 12'h780;
    v = v + 12'(s);
    if (k >= 9) return 8'((k == 9 ? 8'h10 : 8'h20) + s) & {8{g}};
    if (k inside {3, 4, 7, 8} && !g) return 8'h00;
    return k[0] ? v[7:0] : {4'h0, v[11:8]};
  endfunction
  function automatic int base(input int p);
    return (p == 0) ? 0 : u_host.pend[p-1];
  endfunction
  // check host packet p, packet f of a frame holding nt contacts
  task automatic touch_pkt(input int p, input int f, input int nt,
                           input logic [7:0] cnt, input logic g);
    int s, o;
    b = base(p);
    chk("touch length", 59, u_host.pend[p] - b);
    chk("touch id", HTF_RID_TOUCH, u_host.mem[b]);
    for (int r = 0; r < 5; r++) begin
      s = f * 5 + r;
      o = b + 1 + r * 11;
      if (s < nt) chk("detect", 1, u_host.mem[o][0]);
      if (s < nt) chk("contact id", s + 1, u_host.mem[o][7:2]);
      else chk("idle record", 0, u_host.mem[o]);
      for (int k = 1; k < 11; k++)
        chk("record byte", s < nt ? rec(s, k, g) : 8'h00, u_host.mem[o+k]);
    end
    chk("contact count", cnt, u_host.mem[b+58]);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    summarize();
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; slow = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; set_idle_valid = 1'b0; set_idle_value = 8'h00;
    touch_active = '0; touch_x = '0; touch_x2 = '0; touch_y = '0;
    touch_y2 = '0; touch_w = '0; touch_h = '0; bad_count = 0; n_tests = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped place
    apb(1'b0, HTF_OFF_IDLE, 32'h0); chk("idle reset", 32'h2, q);
    apb(1'b0, HTF_OFF_CTRL, 32'h0); chk("ctrl reset", HTF_CTRL_RST, q);
    apb(1'b0, HTF_OFF_VERSION, 32'h0); chk("version", HTF_VERSION_RST, q[15:0]);
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    apb(1'b0, 8'h40, 32'h0); chk("unmapped", 32'h0, q);
    // host set idle request, then idle reports off
    @(posedge pclk); set_idle_valid <= 1'b1; set_idle_value <= 8'h05;
    @(posedge pclk); set_idle_valid <= 1'b0;
    apb(1'b0, HTF_OFF_IDLE, 32'h0); chk("idle set", 32'h5, q);
    @(posedge pclk); set_idle_valid <= 1'b1; set_idle_value <= 8'h00;
    @(posedge pclk); set_idle_valid <= 1'b0;
    // one contact, geometry off
    load(1);
    while (u_host.npkt < 1) @(posedge pclk);
    touch_pkt(0, 0, 1, 8'd1, 1'b0);
    // seven contacts with geometry, host stalling
    apb(1'b1, HTF_OFF_CTRL, 32'h1); slow <= 1'b1;
    load(7);
    while (u_host.npkt < 3) @(posedge pclk);
    touch_pkt(1, 0, 7, 8'd7, 1'b1);
    touch_pkt(2, 1, 7, 8'd0, 1'b1);
    chk("scan time", {u_host.mem[base(1)+57], u_host.mem[base(1)+56]},
        {u_host.mem[base(2)+57], u_host.mem[base(2)+56]});
    // stylus report with every flag set
    apb(1'b1, HTF_OFF_STYLUS, 32'h0000_5A17);
    apb(1'b1, HTF_OFF_STYPOS, 32'h0456_0123);
    apb(1'b1, HTF_OFF_STYCEN, 32'h0789_0ABC);
    apb(1'b1, HTF_OFF_CTRL, 32'h3);
    while (u_host.npkt < 4) @(posedge pclk);
    b = base(3);
    chk("stylus length", 11, u_host.pend[3] - b);
    for (int k = 0; k < 11; k++)
      chk("stylus byte", sty[k], u_host.mem[b+k]);
    // request bit self-clears, two frames counted, endpoint map
    apb(1'b0, HTF_OFF_CTRL, 32'h0); chk("request clear", 32'h1, q);
    apb(1'b0, HTF_OFF_STATUS, 32'h0); chk("status", 32'h0002_0007, q);
    apb(1'b0, HTF_OFF_ENDPT, 32'h0); chk("endpoints", 32'h8302_8100, q);
    repeat (4) @(posedge pclk);
    summarize();
  end
endmodule
